// ---- psm_defines.svh ----
// What this block does
// - sleep and idle are entered only by the power-save instruction
// - sleep stops clocks and halts execution until a wake-up event
// - idle halts the cpu while peripheral clocks keep running
// - enabled interrupt, watchdog time-out or any reset ends sleep or idle
// - sleep shuts down the system clock source and the on-chip oscillator
// - fail-safe clock monitor is off throughout sleep
// - low-power rc clock keeps running in sleep when watchdog is enabled
// - watchdog counter is cleared just before sleep when watchdog is enabled
// - system-clocked peripherals are off in sleep; external-clock ones may run
// - after sleep, execution resumes on the clock source active at entry
// - next oscillator select bits 10:8 are writable only while unlocked
// - bit 3 turns the serial port off, bit 0 the converter
// - bit 2 turns can two off, bit 1 can one off
// - converter off forces analog pin select bits ignored, pins digital
`ifndef PSM_DEFINES_SVH
`define PSM_DEFINES_SVH

`define PSM_ADR_OSC     8'h00
`define PSM_ADR_PMD     8'h04
`define PSM_ADR_STAT    8'h08

`define PSM_NEXT_OSC_HI 10
`define PSM_NEXT_OSC_LO 8
`define PSM_COSC_HI     14
`define PSM_COSC_LO     12
`define PSM_LOCK_BIT    7

`define PSM_PMD_ADC     0
`define PSM_PMD_CAN1    1
`define PSM_PMD_CAN2    2
`define PSM_PMD_SPI     3
`define PSM_NUM_PERIPH  4

`define PSM_ST_WAKE_IRQ 4
`define PSM_ST_WAKE_WDT 5
`define PSM_ST_WDT_EN   6
`define PSM_ST_LOCK     7

`define PSM_PMD_RST     16'h0000
`define PSM_OSC_RST     3'h0
`define PSM_OP_SLEEP    1'h0
`define PSM_OP_IDLE     1'h1

`endif

// ---- psm_pkg.sv ----
package psm_pkg;

   typedef enum logic [1:0] {
      st_run   = 2'b00,
      st_idle  = 2'b01,
      st_prep  = 2'b10,
      st_sleep = 2'b11
   } psm_state_e;

   typedef logic [2:0] psm_osc_t;

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } psm_wb_req_s;

   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
   } psm_wb_rsp_s;

   typedef struct packed {
      logic cpu_run;
      logic sys_clk_en;
      logic osc_on;
      logic fscm_en;
      logic low_power_rc_clock_en;
      logic wdt_clear;
      logic periph_run;
   } psm_clk_ctl_s;

endpackage

// ---- psm_ctrl.sv ----
// Design decisions made here: the address map and the Wishbone register port.
`include "psm_defines.svh"

module psm_ctrl (
   input  wire logic                 core_clk,
   input  wire logic                 rst_b,
   input  wire psm_pkg::psm_wb_req_s wb_req,
   output psm_pkg::psm_wb_rsp_s      wb_rsp,
   input  wire logic                 power_save_instruction,
   input  wire logic                 power_save_operand,
   input  wire logic                 irq_wake,
   input  wire logic                 wdt_timeout_pin,
   input  wire logic                 wdt_enabled,
   input  wire logic                 clk_cfg_locked,
   input  wire logic [15:0]          analog_pin_select,
   output psm_pkg::psm_clk_ctl_s     clk_ctl,
   output psm_pkg::psm_osc_t         osc_active,
   output logic [3:0]                periph_clk_en,
   output logic [3:0]                periph_hold,
   output logic [15:0]               pin_analog_mode
);
   import psm_pkg::*;

   psm_state_e  st_q;
   psm_state_e  next_st;
   psm_osc_t    next_oscillator_select;
   psm_osc_t    cur_osc_q;
   psm_osc_t    sleep_osc_q;
   logic [15:0] pmd_q;
   logic        wake_irq_q;
   logic        wake_wdt_q;
   logic        ack_q;
   logic [31:0] rdat_q;
   logic        wdt_s1;
   logic        wdt_s2;
   logic        wdt_s3;
   logic        wdt_to;

   // watchdog time-out arrives from the rc clock domain
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         wdt_s1 <= 1'b0;
         wdt_s2 <= 1'b0;
         wdt_s3 <= 1'b0;
         wdt_to <= 1'b0;
      end else begin
         wdt_s1 <= wdt_timeout_pin;
         wdt_s2 <= wdt_s1;
         wdt_s3 <= wdt_s2;
         if (wdt_s2 == wdt_s3) begin
            wdt_to <= wdt_s3;
         end
      end
   end

   // bus decode
   wire acc      = wb_req.cyc & wb_req.stb & ~ack_q;
   wire wr       = acc & wb_req.we;
   wire hit_osc  = wb_req.adr == `PSM_ADR_OSC;
   wire hit_pmd  = wb_req.adr == `PSM_ADR_PMD;
   wire hit_stat = wb_req.adr == `PSM_ADR_STAT;
   wire wr_osc   = wr & hit_osc & wb_req.sel[1];
   wire wr_pmd_l = wr & hit_pmd & wb_req.sel[0];
   wire wr_pmd_h = wr & hit_pmd & wb_req.sel[1];
   wire wr_stat  = wr & hit_stat & wb_req.sel[0];
   wire sel_wen  = wr_osc & ~clk_cfg_locked;

   // power-save sequencing
   wire halted    = (st_q == st_idle) | (st_q == st_sleep);
   wire wake      = irq_wake | wdt_to;
   wire req_sleep = power_save_instruction & (power_save_operand == `PSM_OP_SLEEP);
   wire req_idle  = power_save_instruction & (power_save_operand == `PSM_OP_IDLE);

   always_comb begin
      next_st = st_q;
      case (st_q)
         st_run: begin
            if (req_sleep) begin
               next_st = st_prep;
            end else if (req_idle) begin
               next_st = st_idle;
            end
         end
         // one cycle to clear the watchdog before the clocks stop
         st_prep: begin
            next_st = st_sleep;
         end
         st_idle, st_sleep: begin
            if (wake) begin
               next_st = st_run;
            end
         end
         default: begin
            next_st = st_run;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= st_run;
      end else begin
         st_q <= next_st;
      end
   end

   // oscillator selection; the switch itself is only allowed while running
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         next_oscillator_select <= `PSM_OSC_RST;
         cur_osc_q              <= `PSM_OSC_RST;
         sleep_osc_q            <= `PSM_OSC_RST;
      end else begin
         if (sel_wen) begin
            next_oscillator_select <= wb_req.dat[`PSM_NEXT_OSC_HI:`PSM_NEXT_OSC_LO];
         end
         if (st_q == st_prep) begin
            sleep_osc_q <= cur_osc_q;
         end
         if (st_q == st_sleep && next_st == st_run) begin
            cur_osc_q <= sleep_osc_q;
         end else if (st_q == st_run) begin
            cur_osc_q <= next_oscillator_select;
         end
      end
   end

   // peripheral disable word and sticky wake causes; a new wake beats a clear
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         pmd_q      <= `PSM_PMD_RST;
         wake_irq_q <= 1'b0;
         wake_wdt_q <= 1'b0;
      end else begin
         if (wr_pmd_l) begin
            pmd_q[7:0] <= wb_req.dat[7:0];
         end
         if (wr_pmd_h) begin
            pmd_q[15:8] <= wb_req.dat[15:8];
         end
         if (halted & irq_wake) begin
            wake_irq_q <= 1'b1;
         end else if (wr_stat & wb_req.dat[`PSM_ST_WAKE_IRQ]) begin
            wake_irq_q <= 1'b0;
         end
         if (halted & wdt_to) begin
            wake_wdt_q <= 1'b1;
         end else if (wr_stat & wb_req.dat[`PSM_ST_WAKE_WDT]) begin
            wake_wdt_q <= 1'b0;
         end
      end
   end

   // read mux
   wire [31:0] rd_osc = {17'h0_0000, cur_osc_q, 1'h0, next_oscillator_select,
                         clk_cfg_locked, 7'h00};
   wire [31:0] rd_pmd = {16'h0000, pmd_q};
   wire [31:0] rd_st  = {24'h00_0000, clk_cfg_locked, wdt_enabled, wake_wdt_q,
                         wake_irq_q, 2'h0, st_q};
   wire [31:0] rd_mux = hit_osc ? rd_osc :
                        hit_pmd ? rd_pmd :
                        hit_stat ? rd_st : 32'h0000_0000;

   // unmapped addresses are acknowledged and read as zero
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         ack_q  <= 1'b0;
         rdat_q <= 32'h0000_0000;
      end else begin
         ack_q <= acc;
         if (acc) begin
            rdat_q <= rd_mux;
         end
      end
   end

   assign wb_rsp.ack = ack_q;
   assign wb_rsp.dat = rdat_q;

   // clock tree controls
   wire in_sleep = (st_q == st_sleep);
   assign clk_ctl.cpu_run    = (st_q == st_run);
   assign clk_ctl.sys_clk_en = ~in_sleep;
   assign clk_ctl.osc_on     = ~in_sleep;
   assign clk_ctl.fscm_en    = ~in_sleep;
   assign clk_ctl.low_power_rc_clock_en = ~in_sleep | wdt_enabled;
   assign clk_ctl.wdt_clear  = (st_q == st_prep) & wdt_enabled;
   assign clk_ctl.periph_run = ~in_sleep;
   assign osc_active         = cur_osc_q;

   // only system-clocked peripherals are gated here; external-clock ones are not ours
   genvar gi;
   generate
      for (gi = 0; gi < `PSM_NUM_PERIPH; gi = gi + 1) begin : g_periph
         assign periph_clk_en[gi] = ~in_sleep & ~pmd_q[gi];
         assign periph_hold[gi]   = pmd_q[gi];
      end
   endgenerate

   assign pin_analog_mode = pmd_q[`PSM_PMD_ADC] ? 16'h0000 : analog_pin_select;

   a_entry_by_instr:
   assert property (@(posedge core_clk) disable iff (!rst_b)
      (st_q == st_run ##1 st_q != st_run) |-> $past(power_save_instruction))
      else $error("low-power state entered without the instruction");

   a_run_holds:
   assert property (@(posedge core_clk) disable iff (!rst_b)
      (st_q == st_run && !power_save_instruction) |=> (st_q == st_run))
      else $error("run state left with no instruction pending");

   a_sleep_halts:
   assert property (@(posedge core_clk) disable iff (!rst_b)
      (st_q == st_sleep && !wake) |=> (st_q == st_sleep && !clk_ctl.cpu_run))
      else $error("sleep left without a wake-up event");

   a_prep_to_sleep:
   assert property (@(posedge core_clk) disable iff (!rst_b)
      (st_q == st_prep) |=> (in_sleep && !clk_ctl.cpu_run))
      else $error("prep cycle not followed by sleep");

   a_idle_periph:
   assert property (@(posedge core_clk) disable iff (!rst_b)
      (st_q == st_run && req_idle) |=> (!clk_ctl.cpu_run && clk_ctl.periph_run))
      else $error("idle did not halt cpu with peripherals running");

   a_idle_holds:
   assert property (@(posedge core_clk) disable iff (!rst_b)
      (st_q == st_idle && !wake) |=> (st_q == st_idle && clk_ctl.periph_run))
      else $error("idle left or peripherals stopped without a wake-up event");

   a_wake_exit:
   assert property (@(posedge core_clk) disable iff (!rst_b)
      (halted && (irq_wake || wdt_to)) |=> clk_ctl.cpu_run)
      else $error("wake-up event did not resume the cpu");

   a_osc_off:
   assert property (@(posedge core_clk) disable iff (!rst_b)
      (st_q == st_run && req_sleep) |=> ##1 (!clk_ctl.osc_on && !clk_ctl.sys_clk_en))
      else $error("oscillator still on in sleep");

   a_fscm_off:
   assert property (@(posedge core_clk) disable iff (!rst_b)
      in_sleep |-> !clk_ctl.fscm_en)
      else $error("fail-safe monitor active in sleep");

   a_rc_clock_kept:
   assert property (@(posedge core_clk) disable iff (!rst_b)
      (in_sleep && wdt_enabled) |-> clk_ctl.low_power_rc_clock_en)
      else $error("rc clock stopped with watchdog enabled");

   a_wdt_cleared:
   assert property (@(posedge core_clk) disable iff (!rst_b)
      (st_q == st_run && req_sleep && wdt_enabled) |=> clk_ctl.wdt_clear ##1 in_sleep)
      else $error("watchdog not cleared before sleep");

   a_periph_sleep:
   assert property (@(posedge core_clk) disable iff (!rst_b)
      in_sleep |-> (periph_clk_en == 4'h0))
      else $error("peripheral clock running in sleep");

   a_osc_restore:
   assert property (@(posedge core_clk) disable iff (!rst_b)
      (in_sleep && wake) |=> (clk_ctl.cpu_run && osc_active == $past(osc_active)))
      else $error("wake-up on a different clock source");

   a_osc_frozen:
   assert property (@(posedge core_clk) disable iff (!rst_b)
      (st_q == st_prep || in_sleep) |=> $stable(osc_active))
      else $error("clock source changed across sleep");

   a_lock_holds:
   assert property (@(posedge core_clk) disable iff (!rst_b)
      (wr_osc && clk_cfg_locked) |=> $stable(next_oscillator_select))
      else $error("oscillator select changed while locked");

   a_serial_off:
   assert property (@(posedge core_clk) disable iff (!rst_b)
      (wr_pmd_l && wb_req.dat[`PSM_PMD_SPI]) |=>
         (periph_hold[`PSM_PMD_SPI] && !periph_clk_en[`PSM_PMD_SPI]))
      else $error("serial port still running with its disable bit set");

   a_can_one_off:
   assert property (@(posedge core_clk) disable iff (!rst_b)
      (wr_pmd_l && wb_req.dat[`PSM_PMD_CAN1]) |=>
         (periph_hold[`PSM_PMD_CAN1] && !periph_clk_en[`PSM_PMD_CAN1]))
      else $error("can one still running with its disable bit set");

   a_can_two_off:
   assert property (@(posedge core_clk) disable iff (!rst_b)
      (wr_pmd_l && wb_req.dat[`PSM_PMD_CAN2]) |=>
         (periph_hold[`PSM_PMD_CAN2] && !periph_clk_en[`PSM_PMD_CAN2]))
      else $error("can two still running with its disable bit set");

   a_periph_enable:
   assert property (@(posedge core_clk) disable iff (!rst_b)
      (wr_pmd_l && st_q == st_run && wb_req.dat[3:0] == 4'h0) |=>
         (periph_clk_en == 4'hF && periph_hold == 4'h0))
      else $error("peripheral still gated after its disable bit was cleared");

   a_adc_digital:
   assert property (@(posedge core_clk) disable iff (!rst_b)
      (wr_pmd_l && wb_req.dat[`PSM_PMD_ADC]) |=> (pin_analog_mode == 16'h0000))
      else $error("analog pins active with converter off");

   a_adc_analog:
   assert property (@(posedge core_clk) disable iff (!rst_b)
      (wr_pmd_l && !wb_req.dat[`PSM_PMD_ADC]) |=> (pin_analog_mode == analog_pin_select))
      else $error("analog pin select ignored with converter on");

endmodule

// ---- psm_cpu_model.sv ----
module psm_cpu_model (
   input  wire logic core_clk,
   input  wire logic cpu_run,
   output logic      power_save_instruction,
   output logic      power_save_operand,
   output logic      irq_wake,
   output logic      wdt_timeout_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      power_save_instruction = 1'b0;
      power_save_operand = 1'b1;
      irq_wake = 1'b0;
      wdt_timeout_pin = 1'b0;
   end
   // operand carries no meaning outside the pulse, so it shows the inverse then
   task automatic exec(input logic op);
      @(posedge core_clk);
      power_save_instruction <= 1'b1;
      power_save_operand <= op;
      @(posedge core_clk);
      power_save_instruction <= 1'b0;
      power_save_operand <= ~op;
   endtask
   // a wake source stays up until the core is seen running, bounded
   task automatic wake(input logic by_wdt);
      @(posedge core_clk);
      if (by_wdt) wdt_timeout_pin <= 1'b1;
      else irq_wake <= 1'b1;
      for (int n = 0; n < 8; n++) begin
         @(posedge core_clk);
         if (cpu_run === 1'b1) break;
      end
      irq_wake <= 1'b0;
      wdt_timeout_pin <= 1'b0;
   endtask
endmodule

// ---- tb_power_save_mode_control.sv ----
module tb_power_save_mode_control;
   import psm_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic         core_clk;
   logic         rst_b;
   psm_wb_req_s  wb_req;
   psm_wb_rsp_s  wb_rsp;
   logic         power_save_instruction;
   logic         power_save_operand;
   logic         irq_wake;
   logic         wdt_timeout_pin;
   logic         wdt_enabled;
   logic         clk_cfg_locked;
   logic [15:0]  analog_pin_select;
   psm_clk_ctl_s clk_ctl;
   psm_osc_t     osc_active;
   logic [3:0]   periph_clk_en;
   logic [3:0]   periph_hold;
   logic [15:0]  pin_analog_mode;
   int           n_mismatch = 0;
   int           n_compared = 0;

   psm_ctrl psm_ctrl_i (.core_clk(core_clk), .rst_b(rst_b), .wb_req(wb_req), .wb_rsp(wb_rsp),
      .power_save_instruction(power_save_instruction), .power_save_operand(power_save_operand),
      .irq_wake(irq_wake), .wdt_timeout_pin(wdt_timeout_pin), .wdt_enabled(wdt_enabled),
      .clk_cfg_locked(clk_cfg_locked), .analog_pin_select(analog_pin_select),
      .clk_ctl(clk_ctl), .osc_active(osc_active), .periph_clk_en(periph_clk_en),
      .periph_hold(periph_hold), .pin_analog_mode(pin_analog_mode));
   psm_cpu_model psm_cpu_model_i (.core_clk(core_clk), .cpu_run(clk_ctl.cpu_run),
      .power_save_instruction(power_save_instruction), .power_save_operand(power_save_operand),
      .irq_wake(irq_wake), .wdt_timeout_pin(wdt_timeout_pin));

   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   task automatic stop_test();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // classic single cycle; held until ack is sampled, then one idle cycle
   task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                     input logic [31:0] wd, output logic [31:0] rd);
      int n;
      n = 0;
      wb_req <= '{cyc:1'b1, stb:1'b1, we:w, adr:a, sel:s, dat:wd};
      do begin
         @(posedge core_clk);
         n++;
      end while (wb_rsp.ack !== 1'b1 && n < 20);
      rd = wb_rsp.dat;
      wb_req <= '0;
      @(posedge core_clk);
      if (n >= 20) chk("ack", 32'h1, 32'h0);
   endtask

   task automatic wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
      logic [31:0] rd;
      wb(1'b1, a, s, d, rd);
   endtask

   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] rd;
      wb(1'b0, a, 4'hF, 32'h0000_0000, rd);
      chk(nm, exp, rd);
   endtask

   initial begin
      #(40 * 20000);
      n_mismatch++;
      stop_test();
   end

   initial begin
      rst_b = 1'b0;
      wb_req = '0;
      wdt_enabled = 1'b1;
      clk_cfg_locked = 1'b1;
      analog_pin_select = 16'hA5C3;
      repeat (16) @(posedge core_clk);
      rst_b <= 1'b1;
      rdc("pmd", 8'h04, 32'h0000_0000);
      rdc("osc", 8'h00, 32'h0000_0080);
      rdc("status", 8'h08, 32'h0000_00C0);
      rdc("unmapped", 8'h0C, 32'h0000_0000);
      $display("test reset done");
      for (int b = 0; b < 4; b++) begin
         wr(8'h04, 4'h1, 32'h1 << b);
         rdc("pmd", 8'h04, 32'h1 << b);
         chk("hold", 32'h1 << b, {28'h0, periph_hold});
         chk("clk_en", ~(32'h1 << b) & 32'hF, {28'h0, periph_clk_en});
         chk("analog", (b == 0) ? 32'h0 : 32'hA5C3, {16'h0, pin_analog_mode});
      end
      wr(8'h04, 4'h1, 32'h0000_0000);
      analog_pin_select <= 16'h3C5A;
      #1 chk("analog follow", 32'h3C5A, {16'h0, pin_analog_mode});
      @(posedge core_clk);
      $display("test disable done");
      wr(8'h00, 4'h2, 32'h0000_0500);
      rdc("osc locked", 8'h00, 32'h0000_0080);
      clk_cfg_locked <= 1'b0;
      wr(8'h00, 4'h2, 32'h0000_0500);
      rdc("osc open", 8'h00, 32'h0000_5500);
      $display("test osc done");
      psm_cpu_model_i.exec(1'b1);
      #1 chk("idle ctl", 32'h3D, {25'h0, clk_ctl});
      chk("idle clk_en", 32'hF, {28'h0, periph_clk_en});
      psm_cpu_model_i.exec(1'b0);
      @(posedge core_clk);
      #1 chk("still idle", 32'h3D, {25'h0, clk_ctl});
      psm_cpu_model_i.wake(1'b0);
      chk("irq wake", 32'h7D, {25'h0, clk_ctl});
      $display("test idle done");
      psm_cpu_model_i.exec(1'b0);
      #1 chk("prep ctl", 32'h3F, {25'h0, clk_ctl});
      @(posedge core_clk);
      #1 chk("sleep ctl", 32'h04, {25'h0, clk_ctl});
      chk("sleep clk_en", 32'h0, {28'h0, periph_clk_en});
      psm_cpu_model_i.wake(1'b1);
      chk("osc back", 32'h5, {29'h0, osc_active});
      rdc("status", 8'h08, 32'h0000_0070);
      wr(8'h08, 4'h1, 32'h0000_0030);
      rdc("status", 8'h08, 32'h0000_0040);
      $display("test sleep done");
      wdt_enabled <= 1'b0;
      psm_cpu_model_i.exec(1'b0);
      @(posedge core_clk);
      #1 chk("sleep no wdt", 32'h00, {25'h0, clk_ctl});
      @(posedge core_clk);
      rst_b <= 1'b0;
      #1 chk("reset wake", 32'h7D, {25'h0, clk_ctl});
      repeat (16) @(posedge core_clk);
      rst_b <= 1'b1;
      rdc("osc", 8'h00, 32'h0000_0000);
      $display("test reset wake done");
      stop_test();
   end
endmodule
